// *** hw/framing_error_insertion.v ***
// four-link framing error inserter with reference clock outputs and register slave
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "frame_err_regs.vh"

module framing_error_insertion (
    // clock, reset, enable
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        ce,
    // write address
    input  wire [11:0] awaddr,
    input  wire [2:0]  awprot,
    input  wire        awvalid,
    output reg         awready,
    // write data
    input  wire [31:0] wdata,
    input  wire [3:0]  wstrb,
    input  wire        wvalid,
    output reg         wready,
    // write response
    output reg  [1:0]  bresp,
    output reg         bvalid,
    input  wire        bready,
    // read address
    input  wire [11:0] araddr,
    input  wire [2:0]  arprot,
    input  wire        arvalid,
    output reg         arready,
    // read data
    output reg  [31:0] rdata,
    output reg  [1:0]  rresp,
    output reg         rvalid,
    input  wire        rready,
    // line pins
    input  wire [3:0]  los_pin,
    input  wire [3:0]  line_clock_pin,
    input  wire        mclk_pin,
    // reference clock outputs
    output reg         reference_clock_out_a,
    output reg         reference_clock_out_b,
    // transmit streams, one bit per link
    input  wire [3:0]  tx_bit_in,
    input  wire [3:0]  tx_bit_valid,
    input  wire [15:0] tx_field,
    input  wire [3:0]  tx_field_first,
    input  wire [3:0]  tx_field_last,
    output wire [3:0]  tx_bit_out,
    output wire [3:0]  tx_bit_out_valid
);

    // ==========================================
    // address decode: {hit, kind[2:0], link[1:0]}
    localparam [2:0] K_SRC  = 3'h0;
    localparam [2:0] K_REF  = 3'h1;
    localparam [2:0] K_ERR  = 3'h2;
    localparam [2:0] K_CFG  = 3'h3;
    localparam [2:0] K_STAT = 3'h4;

    function [5:0] reg_decode;
        input [11:0] a;
        reg   [9:0]  idx;
        begin
            idx = a[11:2];
            if (a[1:0] != 2'h0)
                reg_decode = 6'h00;
            else if (idx == `IDX_SRC_SEL)
                reg_decode = {1'b1, K_SRC, 2'h0};
            else if (idx[7:0] == `IDX_REF_OUT_CTL)
                reg_decode = {1'b1, K_REF, idx[9:8]};
            else if (idx[7:0] == `IDX_ERR_CTL)
                reg_decode = {1'b1, K_ERR, idx[9:8]};
            else if (idx[7:0] == `IDX_LINK_CFG)
                reg_decode = {1'b1, K_CFG, idx[9:8]};
            else if (idx[7:0] == `IDX_LINK_STAT)
                reg_decode = {1'b1, K_STAT, idx[9:8]};
            else
                reg_decode = 6'h00;
        end
    endfunction

    // ==========================================
    // registers
    reg  [1:0]  sel_a;
    reg  [1:0]  sel_b;
    reg  [3:0]  ref_out_high_on_signal_loss;
    reg  [3:0]  e1_mode;
    reg  [23:0] err_ctl;
    wire [23:0] done;

    // pin synchronisers
    reg  [8:0]  pin_s1;
    reg  [8:0]  pin_s2;
    reg  [8:0]  pin_s3;
    reg  [8:0]  pin_f;
    wire [3:0]  los_f   = pin_f[3:0];
    wire [3:0]  lclk_f  = pin_f[7:4];
    wire        mclk_f  = pin_f[8];

    // write channel
    reg         aw_held;
    reg         w_held;
    reg  [11:0] aw_addr_q;
    reg  [31:0] w_data_q;
    reg  [3:0]  w_strb_q;
    reg         next_aw_held;
    reg         next_w_held;
    reg         next_bvalid;
    reg         next_rvalid;
    wire        do_write = aw_held & w_held & ~bvalid;
    wire [5:0]  wdec     = reg_decode(aw_addr_q);
    wire        wlane    = w_strb_q[0];
    wire [5:0]  rdec     = reg_decode(araddr);

    always @* begin
        next_aw_held = do_write ? 1'b0 : (aw_held | (awvalid & awready));
        next_w_held  = do_write ? 1'b0 : (w_held | (wvalid & wready));
        next_bvalid  = do_write ? 1'b1 : (bvalid & ~bready);
        next_rvalid  = (arvalid & arready) | (rvalid & ~rready);
    end

    // ==========================================
    // bus handshake
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            aw_addr_q <= 12'h000;
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
            awready   <= 1'b0;
            wready    <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= `RESP_OKAY;
            arready   <= 1'b0;
            rvalid    <= 1'b0;
            rresp     <= `RESP_OKAY;
            rdata     <= 32'h00000000;
        end else if (ce) begin
            aw_held <= next_aw_held;
            w_held  <= next_w_held;
            bvalid  <= next_bvalid;
            rvalid  <= next_rvalid;
            awready <= ~next_aw_held & ~next_bvalid;
            wready  <= ~next_w_held & ~next_bvalid;
            arready <= ~next_rvalid;
            if (awvalid & awready)
                aw_addr_q <= awaddr;
            if (wvalid & wready) begin
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (do_write)
                bresp <= wdec[5] ? `RESP_OKAY : `RESP_SLVERR;
            if (arvalid & arready) begin
                rresp <= rdec[5] ? `RESP_OKAY : `RESP_SLVERR;
                rdata <= 32'h00000000;
                case (rdec[4:2])
                    K_SRC:   rdata[7:0] <= rdec[5] ? {3'h0, sel_b, 1'b0, sel_a} : 8'h00;
                    K_REF:   rdata[0]   <= rdec[5] & ref_out_high_on_signal_loss[rdec[1:0]];
                    K_ERR:   rdata[5:0] <= rdec[5] ? err_ctl[rdec[1:0]*6 +: 6] : 6'h00;
                    K_CFG:   rdata[0]   <= rdec[5] & e1_mode[rdec[1:0]];
                    K_STAT:  rdata[0]   <= rdec[5] & los_f[rdec[1:0]];
                    default: rdata      <= 32'h00000000;
                endcase
            end
        end
    end

    // ==========================================
    // register writes and self-clearing control bits
    // source select, shared by both reference outputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            sel_a <= 2'h0;
            sel_b <= 2'h0;
        end else if (ce) begin
            if (do_write && wlane && wdec[5] && wdec[4:2] == K_SRC) begin
                sel_a <= w_data_q[`SEL_A_LSB +: 2];
                sel_b <= w_data_q[`SEL_B_LSB +: 2];
            end
        end
    end

    // per-link control registers
    genvar m;
    generate
        for (m = 0; m < 4; m = m + 1) begin : g_ctl
            localparam [1:0] LINK = m;
            wire       sel  = do_write && wlane && wdec[5] && (wdec[1:0] == LINK);
            wire [5:0] cur  = err_ctl[m*6 +: 6];
            wire [5:0] fin  = done[m*6 +: 6];
            wire [5:0] mask = e1_mode[m] ? `ERR_MASK_E1 : `ERR_MASK_T1;
            wire       swap = sel && (wdec[4:2] == K_CFG)
                              && (w_data_q[`E1_MODE_BIT] != e1_mode[m]);
            // a one arms only where the bit is clear or clears now
            wire [5:0] setb = (sel && wdec[4:2] == K_ERR)
                              ? (w_data_q[5:0] & mask & (~cur | fin)) : 6'h00;

            always @(posedge aclk) begin
                if (!aresetn) begin
                    ref_out_high_on_signal_loss[m] <= `RST_REF_OUT_CTL;
                    e1_mode[m]                     <= `RST_LINK_CFG;
                    err_ctl[m*6 +: 6]              <= `RST_ERR_CTL;
                end else if (ce) begin
                    if (sel && wdec[4:2] == K_REF)
                        ref_out_high_on_signal_loss[m] <= w_data_q[`HIGH_ON_LOSS_BIT];
                    if (swap) begin
                        // mode change drops whatever was pending
                        e1_mode[m]        <= w_data_q[`E1_MODE_BIT];
                        err_ctl[m*6 +: 6] <= 6'h00;
                    end else begin
                        // clear on completion; a new set in the same cycle wins
                        err_ctl[m*6 +: 6] <= (cur & ~fin) | setb;
                    end
                end
            end
        end
    endgenerate

    // ==========================================
    // pin synchronisers, change accepted once stages two and three agree
    always @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1 <= 9'h000;
            pin_s2 <= 9'h000;
            pin_s3 <= 9'h000;
            pin_f  <= 9'h000;
        end else if (ce) begin
            pin_s1 <= {mclk_pin, line_clock_pin, los_pin};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_f  <= (pin_s3 & ~(pin_s2 ^ pin_s3)) | (pin_f & (pin_s2 ^ pin_s3));
        end
    end

    // ==========================================
    // reference clock outputs
    // lost link gives the master clock or a steady high
    function ref_pick;
        input [3:0] lost;
        input [3:0] high;
        input [3:0] line;
        input       master;
        input [1:0] s;
        begin
            if (lost[s])
                ref_pick = high[s] ? 1'b1 : master;
            else
                ref_pick = line[s];
        end
    endfunction

    always @(posedge aclk) begin
        if (!aresetn) begin
            reference_clock_out_a <= 1'b0;
            reference_clock_out_b <= 1'b0;
        end else if (ce) begin
            reference_clock_out_a <= ref_pick(los_f, ref_out_high_on_signal_loss, lclk_f,
                                              mclk_f, sel_a);
            reference_clock_out_b <= ref_pick(los_f, ref_out_high_on_signal_loss, lclk_f,
                                              mclk_f, sel_b);
        end
    end

    // ==========================================
    // per-link corruptors
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_link
            alignment_corruptor u_corrupt (
                .aclk          (aclk),
                .aresetn       (aresetn),
                .ce            (ce),
                .e1_mode       (e1_mode[g]),
                .pending       (err_ctl[g*6 +: 6]),
                .done          (done[g*6 +: 6]),
                .bit_in        (tx_bit_in[g]),
                .bit_valid     (tx_bit_valid[g]),
                .field         (tx_field[g*4 +: 4]),
                .field_first   (tx_field_first[g]),
                .field_last    (tx_field_last[g]),
                .bit_out       (tx_bit_out[g]),
                .bit_out_valid (tx_bit_out_valid[g])
            );
        end
    endgenerate

endmodule
`default_nettype wire

// *** hw/frame_err_regs.vh ***
// register map, field positions and codes of the framing error inserter
`ifndef FRAME_ERR_REGS_VH
`define FRAME_ERR_REGS_VH

// register indices (byte address = index * 4)
`define IDX_SRC_SEL        10'h007
`define IDX_REF_OUT_CTL    8'h3E
`define IDX_ERR_CTL        8'h6F
`define IDX_LINK_CFG       8'hF0
`define IDX_LINK_STAT      8'hF1
`define LINK_STRIDE        10'h100

// field positions
`define SEL_A_LSB          0
`define SEL_B_LSB          3
`define HIGH_ON_LOSS_BIT   0
`define E1_MODE_BIT        0
`define LOS_STAT_BIT       0

// t1/j1 error insertion bits
`define T1_DDS_BIT         3
`define T1_CRC_BIT         2
`define T1_FS_BIT          1
`define T1_FT_BIT          0
// e1 error insertion bits
`define E1_CRC_BIT         5
`define E1_CRCMF_BIT       4
`define E1_CASMF_BIT       3
`define E1_NFAS_BIT        2
`define E1_FASALL_BIT      1
`define E1_FAS1_BIT        0

`define ERR_MASK_T1        6'h0F
`define ERR_MASK_E1        6'h3F

// reset values
`define RST_SRC_SEL        8'h00
`define RST_REF_OUT_CTL    1'b0
`define RST_ERR_CTL        6'h00
`define RST_LINK_CFG       1'b0

// stream field codes
`define FLD_NONE           4'h0
`define FLD_DDS            4'h1
`define FLD_CRC6           4'h2
`define FLD_FS             4'h3
`define FLD_FT             4'h4
`define FLD_CRC4           4'h5
`define FLD_CRCMF          4'h6
`define FLD_CASMF          4'h7
`define FLD_NFAS           4'h8
`define FLD_FAS            4'h9

// bus responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// *** hw/alignment_corruptor.v ***
// one-shot corruption of framing patterns in one link's transmit bit stream
`timescale 1ns/1ns
`default_nettype none
`include "frame_err_regs.vh"

module alignment_corruptor (
    // clock and reset
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       ce,
    // control
    input  wire       e1_mode,
    input  wire [5:0] pending,
    output wire [5:0] done,
    // stream in
    input  wire       bit_in,
    input  wire       bit_valid,
    input  wire [3:0] field,
    input  wire       field_first,
    input  wire       field_last,
    // stream out
    output reg        bit_out,
    output reg        bit_out_valid
);

    // ==========================================
    // bit to field mapping
    function [3:0] target;
        input       e1;
        input [2:0] j;
        begin
            if (e1) begin
                case (j)
                    `E1_CRC_BIT:    target = `FLD_CRC4;
                    `E1_CRCMF_BIT:  target = `FLD_CRCMF;
                    `E1_CASMF_BIT:  target = `FLD_CASMF;
                    `E1_NFAS_BIT:   target = `FLD_NFAS;
                    default:        target = `FLD_FAS;
                endcase
            end else begin
                case (j)
                    `T1_DDS_BIT:    target = `FLD_DDS;
                    `T1_CRC_BIT:    target = `FLD_CRC6;
                    `T1_FS_BIT:     target = `FLD_FS;
                    `T1_FT_BIT:     target = `FLD_FT;
                    default:        target = `FLD_NONE;
                endcase
            end
        end
    endfunction

    // single-bit targets stop after the first bit of the pattern
    function single;
        input       e1;
        input [2:0] j;
        begin
            if (e1)
                single = (j == `E1_NFAS_BIT) || (j == `E1_FAS1_BIT);
            else
                single = (j == `T1_FS_BIT) || (j == `T1_FT_BIT);
        end
    endfunction

    reg  [5:0] active;
    wire [5:0] flip;
    wire [5:0] start;
    wire [5:0] hit;

    // ==========================================
    // per control bit tracking
    genvar j;
    generate
        for (j = 0; j < 6; j = j + 1) begin : g_bit
            localparam [2:0] POS = j;
            wire one = single(e1_mode, POS);
            assign hit[j]   = bit_valid && (field == target(e1_mode, POS))
                              && (target(e1_mode, POS) != `FLD_NONE);
            // only the first bit of an occurrence may start it
            assign start[j] = hit[j] & field_first & pending[j] & ~active[j];
            assign flip[j]  = start[j] | (hit[j] & active[j]);
            assign done[j]  = (start[j] & (one | field_last))
                              | (hit[j] & active[j] & field_last);

            always @(posedge aclk) begin
                if (!aresetn) begin
                    active[j] <= 1'b0;
                end else if (ce) begin
                    active[j] <= (active[j] | (start[j] & ~one)) & ~done[j];
                end
            end
        end
    endgenerate

    // ==========================================
    // output stage
    always @(posedge aclk) begin
        if (!aresetn) begin
            bit_out       <= 1'b0;
            bit_out_valid <= 1'b0;
        end else if (ce) begin
            bit_out       <= bit_in ^ (|flip);
            bit_out_valid <= bit_valid;
        end
    end

endmodule
`default_nettype wire

// *** sim/framing_error_insertion_assertions.sv ***
// checker for bus timing and whole-pattern corruption on link 0
`timescale 1ns/1ns
`default_nettype none
`include "frame_err_regs.vh"
module framing_error_insertion_assertions (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [11:0] araddr,
    input wire logic        rvalid,
    input wire logic [1:0]  rresp,
    // transmit stream
    input wire logic [3:0]  tx_bit_in,
    input wire logic [3:0]  tx_bit_valid,
    input wire logic [15:0] tx_field,
    input wire logic [3:0]  tx_field_first,
    input wire logic [3:0]  tx_bit_out
);
    // ==========================================================
    // helper state: link 0 input seen one cycle back
    logic        vd;
    logic        in_d;
    logic        first_d;
    logic        prev_flip;
    logic [3:0]  fld_d;
    logic [11:0] ar_q;
    wire         flip = tx_bit_out[0] ^ in_d;
    wire         ref_rd = rvalid && ar_q[1:0] == 2'b00 && ar_q[9:2] == `IDX_REF_OUT_CTL;
    always @(posedge aclk) begin
        if (!aresetn) begin
            vd        <= 1'b0;
            in_d      <= 1'b0;
            first_d   <= 1'b0;
            prev_flip <= 1'b0;
            fld_d     <= 4'h0;
            ar_q      <= 12'h000;
        end else begin
            vd      <= tx_bit_valid[0];
            in_d    <= tx_bit_in[0];
            first_d <= tx_field_first[0];
            fld_d   <= tx_field[3:0];
            if (vd)
                prev_flip <= flip;
            if (arvalid && arready)
                ar_q <= araddr;
        end
    end
    // ==========================================================
    // properties
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence rd_taken;
        arvalid && arready;
    endsequence
    sequence occ_tail(code);
        vd && fld_d == code && !first_d;
    endsequence
    // a pattern is flipped whole or not at all
    property whole_occ(code);
        occ_tail(code) |-> flip == prev_flip;
    endproperty
    AST_NONE_CLEAN: assert property (vd && fld_d == `FLD_NONE |-> !flip)
        else $error("bit outside any pattern was altered");
    AST_DDS_WHOLE: assert property (whole_occ(`FLD_DDS))
        else $error("dds pattern flipped in part");
    AST_CRC6_WHOLE: assert property (whole_occ(`FLD_CRC6))
        else $error("crc6 pattern flipped in part");
    AST_CRC4_WHOLE: assert property (whole_occ(`FLD_CRC4))
        else $error("crc4 bits flipped in part");
    AST_CRCMF_WHOLE: assert property (whole_occ(`FLD_CRCMF))
        else $error("crc multiframe pattern flipped in part");
    AST_CASMF_WHOLE: assert property (whole_occ(`FLD_CASMF))
        else $error("signalling multiframe pattern flipped in part");
    AST_REFCTL_OKAY: assert property (ref_rd |-> rresp == `RESP_OKAY)
        else $error("reference clock control read refused");
    AST_MISALIGN_ERR: assert property (rvalid && ar_q[1:0] != 2'b00 |-> rresp == `RESP_SLVERR)
        else $error("misaligned read not refused");
    AST_WR_RESP: assert property (wr_taken |=> !awready && !wready ##1 bvalid)
        else $error("write response timing wrong");
    AST_RD_RESP: assert property (rd_taken |=> rvalid && !arready)
        else $error("read data timing wrong");
endmodule
bind framing_error_insertion framing_error_insertion_assertions chk_u (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rresp(rresp),
    .tx_bit_in(tx_bit_in), .tx_bit_valid(tx_bit_valid), .tx_field(tx_field),
    .tx_field_first(tx_field_first), .tx_bit_out(tx_bit_out)
);
`default_nettype wire

// *** sim/line_far_end.sv ***
// far-end line receiver: counts corrupted bits on link 0, gives loss and recovered clocks
`timescale 1ns/1ns
`default_nettype none
module line_far_end (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // line from the inserter
    input  wire logic [3:0]  tx_bit_out,
    input  wire logic [3:0]  tx_bit_out_valid,
    // line state
    input  wire logic [3:0]  loss,
    output var  logic [3:0]  los_pin,
    output var  logic [3:0]  line_clock_pin,
    output var  logic [15:0] ones_seen
);
    logic [3:0] cnt;
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt            <= 4'h0;
            los_pin        <= 4'h0;
            line_clock_pin <= 4'h0;
            ones_seen      <= 16'h0000;
        end else begin
            cnt     <= cnt + 4'h1;
            los_pin <= loss;
            // recovered clocks stand still while the line is lost
            line_clock_pin <= ~loss & cnt;
            // clean zeros are sent, so each one seen is a corruption
            if (tx_bit_out_valid[0] && tx_bit_out[0])
                ones_seen <= ones_seen + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// *** sim/framing_error_insertion_test.sv ***
// bench: register access, one-shot pattern corruption, reference clock outputs
`timescale 1ns/1ns
`default_nettype none
`include "frame_err_regs.vh"
module framing_error_insertion_test;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, mclk_pin;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata;
    logic [3:0]  loss, tx_bit_valid, tx_field_first, tx_field_last;
    logic [15:0] tx_field;
    wire         awready, wready, bvalid, arready, rvalid, ref_a, ref_b;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [3:0]  los_pin, line_clock_pin, tx_bit_out, tx_bit_out_valid;
    wire  [15:0] ones_seen;
    logic [15:0] base;
    logic [3:0]  s;
    int          errors, samples_checked;
    int          t_bit [10] = '{3, 2, 1, 0, 5, 4, 3, 2, 1, 0};
    int          t_len [10] = '{6, 6, 1, 1, 4, 6, 4, 1, 7, 7};
    int          t_exp [10] = '{6, 6, 1, 1, 4, 6, 4, 1, 7, 1};
    logic [3:0]  t_code [10] = '{`FLD_DDS, `FLD_CRC6, `FLD_FS, `FLD_FT, `FLD_CRC4,
                                 `FLD_CRCMF, `FLD_CASMF, `FLD_NFAS, `FLD_FAS, `FLD_FAS};

    framing_error_insertion dut_u (
        .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .los_pin(los_pin), .line_clock_pin(line_clock_pin), .mclk_pin(mclk_pin),
        .reference_clock_out_a(ref_a), .reference_clock_out_b(ref_b),
        .tx_bit_in(4'h0), .tx_bit_valid(tx_bit_valid), .tx_field(tx_field),
        .tx_field_first(tx_field_first), .tx_field_last(tx_field_last),
        .tx_bit_out(tx_bit_out), .tx_bit_out_valid(tx_bit_out_valid)
    );
    line_far_end line_u (
        .aclk(aclk), .aresetn(aresetn), .tx_bit_out(tx_bit_out),
        .tx_bit_out_valid(tx_bit_out_valid), .loss(loss), .los_pin(los_pin),
        .line_clock_pin(line_clock_pin), .ones_seen(ones_seen)
    );
    // ==========================================================
    // clocks and watchdog
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    // master clock slow enough for the pin filter
    logic [2:0]  mdiv = 3'h0;
    always @(posedge aclk) begin
        mdiv     <= mdiv + 3'h1;
        mclk_pin <= mdiv[2];
    end
    initial begin
        repeat (6000) @(posedge aclk);
        errors++;
        print_verdict;
    end
    // ==========================================================
    // tasks
    function automatic logic [11:0] ba(input logic [9:0] idx);
        return {idx, 2'b00};
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (!ad && awready) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wd && wready) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b0;
    endtask
    task automatic rd(input string what, input logic [11:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        chk(what, e, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        rready <= 1'b0;
    endtask
    task automatic send(input logic [3:0] code, input int n);
        for (int i = 0; i < n; i++) begin
            tx_bit_valid[0] <= 1'b1;
            tx_field[3:0] <= code;
            tx_field_first[0] <= (i == 0);
            tx_field_last[0] <= (i == n - 1);
            @(posedge aclk);
        end
        tx_bit_valid[0] <= 1'b0;
        tx_field[3:0] <= `FLD_NONE;
        repeat (3) @(posedge aclk);
    endtask
    task automatic watch;
        s = 4'h0;
        repeat (16) begin
            @(posedge aclk);
            s = s | {ref_a, ~ref_a, ref_b, ~ref_b};
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        errors = 0;
        samples_checked = 0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, mclk_pin} = 6'h00;
        {awaddr, araddr, wdata} = 56'h0;
        {loss, tx_bit_valid, tx_field_first, tx_field_last, tx_field} = 32'h0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd("error control reset", ba(`IDX_ERR_CTL), 32'h0, `RESP_OKAY);
        rd("unmapped read", ba(10'h3FF), 32'h0, `RESP_SLVERR);
        rd("misaligned read", 12'h1BD, 32'h0, `RESP_SLVERR);
        wr(ba(10'h3FF), 32'h1, `RESP_SLVERR);
        for (int g = 0; g < 4; g++) begin
            rd("ref control reset", ba({g[1:0], `IDX_REF_OUT_CTL}), 32'h0, `RESP_OKAY);
            wr(ba({g[1:0], `IDX_REF_OUT_CTL}), {31'h0, g[1] ^ g[0]}, `RESP_OKAY);
        end
        for (int g = 0; g < 4; g++)
            rd("ref control", ba({g[1:0], `IDX_REF_OUT_CTL}), {31'h0, g[1] ^ g[0]}, `RESP_OKAY);
        // first four entries in t1 mode, rest in e1 mode
        for (int k = 0; k < 10; k++) begin
            if (k == 4)
                wr(ba(`IDX_LINK_CFG), 32'h1, `RESP_OKAY);
            wr(ba(`IDX_ERR_CTL), 32'h1 << t_bit[k], `RESP_OKAY);
            rd("armed bit", ba(`IDX_ERR_CTL), 32'h1 << t_bit[k], `RESP_OKAY);
            base = ones_seen;
            send(`FLD_NONE, 2);
            send(t_code[k], t_len[k]);
            chk("flipped bits", t_exp[k], {16'h0, ones_seen - base});
            rd("self clear", ba(`IDX_ERR_CTL), 32'h0, `RESP_OKAY);
            send(t_code[k], t_len[k]);
            chk("repeat flips", t_exp[k], {16'h0, ones_seen - base});
        end
        rd("link mode", ba(`IDX_LINK_CFG), 32'h1, `RESP_OKAY);
        // out a from link 2 (steady high on loss), out b from link 3 (master clock)
        wr(ba(`IDX_SRC_SEL), 32'h1A, `RESP_OKAY);
        rd("source select", ba(`IDX_SRC_SEL), 32'h1A, `RESP_OKAY);
        loss <= 4'hC;
        repeat (10) @(posedge aclk);
        watch;
        chk("ref outputs on loss", 32'hB, {28'h0, s});
        rd("loss status", ba({2'h2, `IDX_LINK_STAT}), 32'h1, `RESP_OKAY);
        loss <= 4'h0;
        repeat (10) @(posedge aclk);
        watch;
        chk("ref outputs on line", 32'hF, {28'h0, s});
        print_verdict;
    end
endmodule
`default_nettype wire
